// >>> hw/adc_pkg.sv
package adc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Conversion word layout, most significant bit first
   localparam int WORD_W = 32;
   localparam int RESULT_W = 20;
   localparam int PAD_W = 4;
   localparam int STATUS_W = 8;
   localparam int BIT_CNT_W = 6;
   localparam logic [1:0] CHECK_OK = 2'h1;
   localparam logic STATUS_READY = 1'b0;
   // Timing in printed units, cycles derived from the clock
   localparam int STARTUP_MS = 1;
   localparam int CONV_SLOW_MS = 100;
   localparam int CONV_FAST_MS = 60;
   localparam int PD_LOW_NS = 100;
   localparam int STARTUP_CYCLES = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_SLOW_CYCLES = CONV_SLOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_FAST_CYCLES = CONV_FAST_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PD_LOW_CYCLES = (PD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_HIGH_CYCLES = 64;
   localparam int SCLK_HALF_CYCLES = 8;
   localparam int TICK_W = 24;
   localparam logic [1:0] SETTLE_SLOW = 2'h3;
   localparam logic [1:0] SETTLE_FAST = 2'h2;
   localparam int FIFO_DEPTH = 4;
endpackage : adc_pkg

// >>> hw/adc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
   logic sclk;
   logic dout;
   logic dout_oe_n;
   logic powerdown_reset_n;
   logic filter_sel;
   logic gain_sel;
   // Pull-up holds the shared line high while the device floats it
   wire logic data_line;
   assign data_line = dout_oe_n ? 1'b1 : dout;
   modport device (input sclk, input powerdown_reset_n, input filter_sel, input gain_sel,
                   output dout, output dout_oe_n);
   modport host (output sclk, output powerdown_reset_n, output filter_sel,
                 output gain_sel, input data_line);
endinterface : adc_link_if
`default_nettype wire

// >>> hw/adc_device.sv
// Functional notes
// - Line goes low when new word loaded
// - Host clocks out a 32-bit word
// - Result, four zeros, then status bits
// - Line returns high after full read
// - Unread word: line high before update
// - Every settled conversion loaded; read only once
// - Completion resets serial interface; host reads first
// - Line floated while powered down
// - Startup delay, then continuous conversions with settling
// - Line high at wake, low when available
// - Filter/gain change restarts, line high until settled
// - Host finishes reads before setting changes
// - Status ready, filter and gain bits
// - Error bit marks out-of-range input
// - Fixed two-bit part code in status
// - Check pattern 01; host rejects 00, 1x
// - Bridge switch open in power-down only
// - Filter low fast two cycles, high slow three
// - Gain low is 128, high unity
// - Power-down low resets all logic
// - Result is offset binary
`timescale 1ns/1ps
`default_nettype none
module adc_device
   import adc_pkg::*;
#(
   parameter int CONV_SLOW_CYC = CONV_SLOW_CYCLES,
   parameter int CONV_FAST_CYC = CONV_FAST_CYCLES,
   parameter int STARTUP_CYC = STARTUP_CYCLES,
   parameter int PRE_HIGH_CYC = PRE_HIGH_CYCLES,
   // Arbitrary part code value
   parameter logic [1:0] PART_CODE = 2'h2
) (
   input wire logic clock_i,                      // 100 MHz clock
   input wire logic rst_n_i,                      // Async reset, active low
   adc_link_if.device link,                       // Serial link pins
   input wire logic [RESULT_W-1:0] conv_result_i, // Offset binary result
   input wire logic conv_error_i,                 // Input out of range
   output logic conv_done_o,                      // Conversion completed pulse
   output logic bridge_low_side_switch_o          // High while switch closed
);
   if (CONV_FAST_CYC <= 2 * PRE_HIGH_CYC || CONV_SLOW_CYC >= (1 << TICK_W) ||
       STARTUP_CYC < 2 || STARTUP_CYC >= (1 << TICK_W)) begin : g_chk
      $error("adc_device: timing parameters out of range");
   end

   typedef enum logic [2:0] {
      ST_OFF = 3'h1,
      ST_START = 3'h2,
      ST_RUN = 3'h4
   } dev_state_type;

   // Pin synchronisers; only stage 1 and later are read by logic
   logic [2:0] sclk_s_r;
   logic [1:0] pd_s_r;
   logic [1:0] filt_s_r;
   logic [1:0] gain_s_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_s_r <= 3'h7;
         pd_s_r <= 2'h0;
         filt_s_r <= 2'h0;
         gain_s_r <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], link.sclk};
         pd_s_r <= {pd_s_r[0], link.powerdown_reset_n};
         filt_s_r <= {filt_s_r[0], link.filter_sel};
         gain_s_r <= {gain_s_r[0], link.gain_sel};
      end
   end

   wire logic sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];
   wire logic sclk_rise = ~sclk_s_r[2] & sclk_s_r[1];

   dev_state_type state_r, state_nxt;
   logic [TICK_W-1:0] tick_r, tick_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic [WORD_W-1:0] word_r, word_nxt;
   logic [BIT_CNT_W-1:0] bits_r, bits_nxt;
   logic avail_r, avail_nxt;
   logic reading_r, reading_nxt;
   logic line_r, line_nxt;
   logic filt_q_r, filt_q_nxt;
   logic gain_q_r, gain_q_nxt;
   logic done_r, done_nxt;
   logic [TICK_W-1:0] period;
   logic [1:0] settle_load;

   always_comb begin
      state_nxt = state_r;
      tick_nxt = tick_r;
      settle_nxt = settle_r;
      word_nxt = word_r;
      bits_nxt = bits_r;
      avail_nxt = avail_r;
      reading_nxt = reading_r;
      line_nxt = line_r;
      filt_q_nxt = filt_q_r;
      gain_q_nxt = gain_q_r;
      done_nxt = 1'b0;
      period = filt_q_r ? TICK_W'(CONV_SLOW_CYC) : TICK_W'(CONV_FAST_CYC);
      settle_load = filt_s_r[1] ? SETTLE_SLOW : SETTLE_FAST;
      unique case (state_r)
         ST_OFF: begin
            tick_nxt = '0;
            avail_nxt = 1'b0;
            reading_nxt = 1'b0;
            line_nxt = 1'b1;
            if (pd_s_r[1]) begin
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            tick_nxt = tick_r + TICK_W'(1);
            if (tick_r == TICK_W'(STARTUP_CYC - 1)) begin
               state_nxt = ST_RUN;
               tick_nxt = '0;
               settle_nxt = settle_load;
               filt_q_nxt = filt_s_r[1];
               gain_q_nxt = gain_s_r[1];
            end
         end
         ST_RUN: begin
            if (filt_s_r[1] != filt_q_r || gain_s_r[1] != gain_q_r) begin
               // Restart conversions; any read in progress now clocks ones
               filt_q_nxt = filt_s_r[1];
               gain_q_nxt = gain_s_r[1];
               tick_nxt = '0;
               settle_nxt = settle_load;
               avail_nxt = 1'b0;
               reading_nxt = 1'b0;
               line_nxt = 1'b1;
            end else if (tick_r == period - TICK_W'(1)) begin
               tick_nxt = '0;
               done_nxt = 1'b1;
               if (settle_r > 2'h1) begin
                  settle_nxt = settle_r - 2'h1;
               end else begin
                  // New word replaces old one and restarts the shifter
                  word_nxt = {conv_result_i, {PAD_W{1'b0}},
                              STATUS_READY, filt_q_r,
                              conv_error_i, PART_CODE,
                              gain_q_r, CHECK_OK};
                  bits_nxt = '0;
                  avail_nxt = 1'b1;
                  reading_nxt = 1'b0;
                  line_nxt = 1'b0;
               end
            end else begin
               tick_nxt = tick_r + TICK_W'(1);
               if (tick_r == period - TICK_W'(PRE_HIGH_CYC) && avail_r && !reading_r) begin
                  avail_nxt = 1'b0;
                  line_nxt = 1'b1;
               end else if (sclk_fall && avail_r) begin
                  // Fill with ones so extra clocks read high
                  reading_nxt = 1'b1;
                  line_nxt = word_r[WORD_W-1];
                  word_nxt = {word_r[WORD_W-2:0], 1'b1};
               end else if (sclk_rise && reading_r) begin
                  bits_nxt = bits_r + BIT_CNT_W'(1);
                  if (bits_r == BIT_CNT_W'(WORD_W - 1)) begin
                     avail_nxt = 1'b0;
                     reading_nxt = 1'b0;
                     line_nxt = 1'b1;
                  end
               end
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
      if (!pd_s_r[1]) begin
         state_nxt = ST_OFF;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_OFF;
         tick_r <= '0;
         settle_r <= '0;
         word_r <= '1;
         bits_r <= '0;
         avail_r <= 1'b0;
         reading_r <= 1'b0;
         line_r <= 1'b1;
         filt_q_r <= 1'b0;
         gain_q_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tick_r <= tick_nxt;
         settle_r <= settle_nxt;
         word_r <= word_nxt;
         bits_r <= bits_nxt;
         avail_r <= avail_nxt;
         reading_r <= reading_nxt;
         line_r <= line_nxt;
         filt_q_r <= filt_q_nxt;
         gain_q_r <= gain_q_nxt;
         done_r <= done_nxt;
      end
   end

   assign link.dout = line_r;
   assign link.dout_oe_n = (state_r == ST_OFF);
   assign bridge_low_side_switch_o = (state_r != ST_OFF);
   assign conv_done_o = done_r;
endmodule : adc_device
`default_nettype wire

// >>> hw/adc_host.sv
`timescale 1ns/1ps
`default_nettype none
module adc_word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   input wire logic clock_i,           // Clock
   input wire logic rst_n_i,           // Async reset, active low
   input wire logic in_valid_i,        // Write request
   output logic in_ready_o,            // Space available
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic out_valid_o,           // Data available
   input wire logic out_ready_i,       // Reader takes data
   output logic [WIDTH-1:0] out_data_o // Head of queue
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("adc_word_fifo: depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic push, pop;

   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_nxt = push ? wp_r + PW'(1) : wp_r;
      rp_nxt = pop ? rp_r + PW'(1) : rp_r;
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rp_r];
endmodule : adc_word_fifo

module adc_host
   import adc_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock_i,              // 100 MHz clock
   input wire logic rst_n_i,              // Async reset, active low
   adc_link_if.host link,                 // Serial link pins
   input wire logic powerdown_req_i,      // Request device power-down
   input wire logic filter_sel_i,         // 1: slow filter
   input wire logic gain_sel_i,           // 1: unity gain
   output logic word_valid_o,             // Received word available
   input wire logic word_ready_i,         // User takes word
   output logic [WORD_W-1:0] word_o,      // Received 32-bit word
   output logic xfer_error_o              // Check pattern failed
);
   if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_chk
      $error("adc_host: half period too short for synchroniser lag");
   end

   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_LOW = 4'h2,
      H_HIGH = 4'h4,
      H_WAIT = 4'h8
   } host_state_type;

   logic [1:0] line_s_r;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_s_r <= 2'h3;
      end else begin
         line_s_r <= {line_s_r[0], link.data_line};
      end
   end

   host_state_type state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [BIT_CNT_W-1:0] bits_r, bits_nxt;
   logic [WORD_W-1:0] shift_r, shift_nxt;
   logic sclk_r, sclk_nxt;
   logic pd_n_r, pd_n_nxt;
   logic filt_r, filt_nxt;
   logic gain_r, gain_nxt;
   logic [7:0] pd_cnt_r, pd_cnt_nxt;
   logic push;
   logic fifo_ready;
   logic [WORD_W:0] fifo_out;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      bits_nxt = bits_r;
      shift_nxt = shift_r;
      sclk_nxt = sclk_r;
      pd_n_nxt = pd_n_r;
      filt_nxt = filt_r;
      gain_nxt = gain_r;
      pd_cnt_nxt = (pd_cnt_r != '0) ? pd_cnt_r - 8'h1 : pd_cnt_r;
      push = 1'b0;
      unique case (state_r)
         H_IDLE: begin
            // Pin changes only between reads
            filt_nxt = filter_sel_i;
            gain_nxt = gain_sel_i;
            if (powerdown_req_i && pd_n_r) begin
               pd_n_nxt = 1'b0;
               pd_cnt_nxt = 8'(PD_LOW_CYCLES);
            end else if (!powerdown_req_i && !pd_n_r && pd_cnt_r == '0) begin
               pd_n_nxt = 1'b1;
            end else if (filt_r != filter_sel_i || gain_r != gain_sel_i) begin
               // Device lags the pins; a stale low would start a read of ones
               state_nxt = H_WAIT;
               cnt_nxt = '0;
            end else if (pd_n_r && !line_s_r[1] && fifo_ready &&
                         filt_r == filter_sel_i && gain_r == gain_sel_i) begin
               state_nxt = H_LOW;
               sclk_nxt = 1'b0;
               cnt_nxt = '0;
               bits_nxt = '0;
            end
         end
         H_LOW: begin
            cnt_nxt = cnt_r + 8'h1;
            if (cnt_r == 8'(HALF_CYC - 1)) begin
               sclk_nxt = 1'b1;
               shift_nxt = {shift_r[WORD_W-2:0], line_s_r[1]};
               bits_nxt = bits_r + BIT_CNT_W'(1);
               cnt_nxt = '0;
               state_nxt = H_HIGH;
            end
         end
         H_HIGH: begin
            cnt_nxt = cnt_r + 8'h1;
            if (cnt_r == 8'(HALF_CYC - 1)) begin
               cnt_nxt = '0;
               if (bits_r == BIT_CNT_W'(WORD_W)) begin
                  push = 1'b1;
                  state_nxt = H_WAIT;
               end else begin
                  sclk_nxt = 1'b0;
                  state_nxt = H_LOW;
               end
            end
         end
         H_WAIT: begin
            // Stale low must clear, and the device see any change, before a read
            cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h1;
            if (line_s_r[1] && cnt_r >= 8'(HALF_CYC)) begin
               state_nxt = H_IDLE;
            end
         end
         default: begin
            state_nxt = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= H_IDLE;
         cnt_r <= '0;
         bits_r <= '0;
         shift_r <= '0;
         sclk_r <= 1'b1;
         pd_n_r <= 1'b0;
         filt_r <= 1'b0;
         gain_r <= 1'b0;
         pd_cnt_r <= 8'(PD_LOW_CYCLES);
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         bits_r <= bits_nxt;
         shift_r <= shift_nxt;
         sclk_r <= sclk_nxt;
         pd_n_r <= pd_n_nxt;
         filt_r <= filt_nxt;
         gain_r <= gain_nxt;
         pd_cnt_r <= pd_cnt_nxt;
      end
   end

   adc_word_fifo #(.WIDTH(WORD_W + 1), .DEPTH(DEPTH)) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i({shift_r[1] | ~shift_r[0], shift_r}),
      .out_valid_o(word_valid_o),
      .out_ready_i(word_ready_i),
      .out_data_o(fifo_out)
   );

   assign word_o = fifo_out[WORD_W-1:0];
   assign xfer_error_o = fifo_out[WORD_W];
   assign link.sclk = sclk_r;
   assign link.powerdown_reset_n = pd_n_r;
   assign link.filter_sel = filt_r;
   assign link.gain_sel = gain_r;
endmodule : adc_host
`default_nettype wire

// >>> test/adc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adc_link_chk (
   input wire logic clock_i,           // 100 MHz clock
   input wire logic rst_n_i,           // Async reset, active low
   input wire logic sclk,              // Serial clock from host
   input wire logic dout,              // Device data/ready-low
   input wire logic dout_oe_n,         // Device output enable, low drives
   input wire logic powerdown_reset_n, // Power-down/reset, active low
   input wire logic filter_sel,        // Filter select pin
   input wire logic gain_sel,          // Gain select pin
   input wire logic data_line          // Resolved shared line
);
   logic sclk_d_r;
   logic [4:0] hi_cnt_r;
   logic [5:0] edge_cnt_r;
   logic rise;
   assign rise = sclk && !sclk_d_r;
   // Long high stretch marks the gap between frames
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_d_r <= 1'b1;
         hi_cnt_r <= 5'h0;
         edge_cnt_r <= 6'h0;
      end else begin
         sclk_d_r <= sclk;
         hi_cnt_r <= !sclk ? 5'h0 : (hi_cnt_r == 5'h1F ? hi_cnt_r : hi_cnt_r + 5'h1);
         if (hi_cnt_r == 5'hF) edge_cnt_r <= 6'h0;
         else if (rise) edge_cnt_r <= edge_cnt_r + 6'h1;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_float_pd; !powerdown_reset_n [*4] |-> dout_oe_n; endproperty
   property p_sclk_pd; !powerdown_reset_n |-> sclk; endproperty
   property p_low_phase; $fell(sclk) |-> !sclk [*6]; endproperty
   property p_high_phase; rise |-> sclk [*6]; endproperty
   property p_setting_high;
      ($changed(filter_sel) || $changed(gain_sel)) |-> ##5 data_line [*8];
   endproperty
   property p_wake_high; $rose(powerdown_reset_n) |-> data_line [*8]; endproperty
   property p_edge_limit; edge_cnt_r <= 6'h20; endproperty
   property p_pad_zero; rise && edge_cnt_r >= 6'h14 && edge_cnt_r <= 6'h17 |-> !data_line;
   endproperty
   property p_ready_bit; rise && edge_cnt_r == 6'h18 |-> !data_line; endproperty
   property p_check_bits;
      rise && edge_cnt_r == 6'h1E |-> !data_line ##[10:20] (rise && data_line);
   endproperty
   property p_end_high; rise && edge_cnt_r == 6'h1F |-> ##6 data_line [*4]; endproperty
   a_float_pd: assert property (p_float_pd) else $error("line driven in power-down");
   a_sclk_pd: assert property (p_sclk_pd) else $error("clock not idle high");
   a_low_phase: assert property (p_low_phase) else $error("clock low too short");
   a_high_phase: assert property (p_high_phase) else $error("clock high too short");
   a_setting_high: assert property (p_setting_high) else $error("line low after change");
   a_wake_high: assert property (p_wake_high) else $error("line low at wake");
   a_edge_limit: assert property (p_edge_limit) else $error("frame over 32 bits");
   a_pad_zero: assert property (p_pad_zero) else $error("pad bit not zero");
   a_ready_bit: assert property (p_ready_bit) else $error("ready bit not zero");
   a_check_bits: assert property (p_check_bits) else $error("check pattern wrong");
   a_end_high: assert property (p_end_high) else $error("line low after word");
   c_word: cover property (rise && edge_cnt_r == 6'h1F);
   c_wake: cover property ($rose(powerdown_reset_n));
   c_setting: cover property ($changed(filter_sel) || $changed(gain_sel));
endmodule : adc_link_chk
`default_nettype wire

// >>> test/bridge_adc_serial_readout_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_adc_serial_readout_bench;
   import adc_pkg::*;
   localparam int SLOW = 2000;
   localparam int FAST = 1200;
   localparam int START = 50;
   localparam logic [1:0] CODE = 2'h2; // Arbitrary part code
   logic clock_i, rst_n_i, pd_req, filt, gain, ready, conv_err, conv_done, sw, wvalid, xerr;
   logic [RESULT_W-1:0] conv_res;
   logic [WORD_W-1:0] word;
   logic [RESULT_W-1:0] res_tab [4] = '{20'h00000, 20'h80000, 20'hFFFFF, 20'h5A5A5};
   int mismatches, tests_run, n, i, ns, p;
   adc_link_if adc_link_if_inst ();
   adc_device #(.CONV_SLOW_CYC(SLOW), .CONV_FAST_CYC(FAST), .STARTUP_CYC(START),
      .PRE_HIGH_CYC(64), .PART_CODE(CODE)) adc_device_inst (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .link(adc_link_if_inst.device), .conv_result_i(conv_res),
      .conv_error_i(conv_err), .conv_done_o(conv_done), .bridge_low_side_switch_o(sw));
   adc_host #(.HALF_CYC(8), .DEPTH(4)) adc_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .link(adc_link_if_inst.host), .powerdown_req_i(pd_req), .filter_sel_i(filt),
      .gain_sel_i(gain), .word_valid_o(wvalid), .word_ready_i(ready), .word_o(word),
      .xfer_error_o(xerr));
   adc_link_chk adc_link_chk_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .sclk(adc_link_if_inst.sclk), .dout(adc_link_if_inst.dout),
      .dout_oe_n(adc_link_if_inst.dout_oe_n),
      .powerdown_reset_n(adc_link_if_inst.powerdown_reset_n),
      .filter_sel(adc_link_if_inst.filter_sel), .gain_sel(adc_link_if_inst.gain_sel),
      .data_line(adc_link_if_inst.data_line));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task complete_run;
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task check_val(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task check_range(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : check_range
   function automatic logic [WORD_W-1:0] exp_word(input logic [RESULT_W-1:0] r,
      input logic e, input logic f, input logic g);
      return {r, 4'h0, STATUS_READY, f, e, CODE, g, CHECK_OK};
   endfunction : exp_word
   task wait_done;
      int k;
      k = 0;
      do begin
         @(negedge clock_i);
         k++;
      end while (conv_done !== 1'b1 && k < 5000);
      if (conv_done !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t no conversion completed", $time);
      end
   endtask : wait_done
   task wait_line(output int k);
      k = 0;
      while (adc_link_if_inst.data_line !== 1'b0 && k < 20000) begin
         @(negedge clock_i);
         k++;
      end
   endtask : wait_line
   // Holding ready drains one word per cycle
   task flush;
      ready = 1'b1;
      while (wvalid === 1'b1) @(negedge clock_i);
      ready = 1'b0;
   endtask : flush
   task get_word(input logic [WORD_W-1:0] exp);
      int k;
      k = 0;
      while (wvalid !== 1'b1 && k < 3000) begin
         @(negedge clock_i);
         k++;
      end
      check_val(word, exp);
      check_val({31'h0, xerr}, 32'h0);
      ready = 1'b1;
      @(negedge clock_i);
      ready = 1'b0;
   endtask : get_word
   initial begin
      pd_req = 1'b0;
      filt = 1'b1;
      gain = 1'b1;
      ready = 1'b0;
      conv_res = '0;
      conv_err = 1'b0;
      rst_n_i = 1'b0;
      mismatches = 0;
      tests_run = 0;
      repeat (6) @(negedge clock_i);
      rst_n_i = 1'b1;
      wait_line(n);
      flush;
      for (i = 0; i < 4; i++) begin
         conv_res = res_tab[i];
         conv_err = i[0] ^ i[1];
         filt = i[0];
         gain = i[1];
         ns = i[0] ? 3 : 2;
         p = i[0] ? SLOW : FAST;
         n = 0;
         while ((adc_link_if_inst.filter_sel !== filt || adc_link_if_inst.gain_sel !== gain)
                && n < 3000) begin
            @(negedge clock_i);
            n++;
         end
         repeat (6) @(negedge clock_i);
         wait_line(n);
         check_range(n + 6, ns * p - 10, ns * p + 20);
         flush;
         get_word(exp_word(conv_res, conv_err, filt, gain));
      end
      pd_req = 1'b1;
      n = 0;
      while (adc_link_if_inst.powerdown_reset_n !== 1'b0 && n < 1000) begin
         @(negedge clock_i);
         n++;
      end
      repeat (10) @(negedge clock_i);
      check_val({31'h0, adc_link_if_inst.dout_oe_n}, 32'h1);
      check_val({31'h0, sw}, 32'h0);
      n = 0;
      repeat (1500) begin
         @(negedge clock_i);
         if (conv_done === 1'b1) n++;
      end
      check_range(n, 0, 0);
      pd_req = 1'b0;
      while (adc_link_if_inst.powerdown_reset_n !== 1'b1) @(negedge clock_i);
      wait_line(n);
      check_range(n, START + 3 * SLOW - 10, START + 3 * SLOW + 30);
      check_val({31'h0, sw}, 32'h1);
      flush;
      get_word(exp_word(conv_res, conv_err, 1'b1, 1'b1));
      // Host stalls; four words buffered, the next two dropped
      conv_res = 20'h00010;
      wait_done;
      repeat (700) @(negedge clock_i);
      flush;
      for (i = 0; i < 6; i++) begin
         conv_res = i[RESULT_W-1:0];
         wait_done;
      end
      conv_res = 20'h00009;
      repeat (10) @(negedge clock_i);
      check_val({31'h0, adc_link_if_inst.data_line}, 32'h0);
      check_val({31'h0, wvalid}, 32'h1);
      repeat (SLOW - 66) @(negedge clock_i);
      check_val({31'h0, adc_link_if_inst.data_line}, 32'h1);
      wait_done;
      for (i = 0; i < 4; i++) begin
         get_word(exp_word(i[RESULT_W-1:0], 1'b0, 1'b1, 1'b1));
      end
      get_word(exp_word(20'h00009, 1'b0, 1'b1, 1'b1));
      complete_run();
   end
   initial begin
      #800000;
      mismatches++;
      complete_run();
   end
endmodule : bridge_adc_serial_readout_bench
`default_nettype wire
